// >>> src/pbf_framer.sv
// Packet bus framer: tx buffer flow control, burst control words, rx marking
`timescale 1ns/1ps
`default_nettype none
module pbf_framer
  import pbf_pkg::*;
#(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 16
)(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire pbf_beat_type i_tx_beat,
  input wire logic i_tx_bcw_force,
  input wire logic [7:0] i_tx_thresh,
  input wire logic i_lane_ready,
  output logic o_tx_backpressure,
  output logic o_tx_overflow,
  output logic o_tx_lane_valid,
  output logic [PBF_DW-1:0] o_tx_lane_data,
  output logic o_tx_lane_bcw,
  input wire pbf_beat_type i_rx_lane_beat,
  input wire logic i_rx_ready,
  output pbf_rxout_type o_rx_beat,
  input wire pbf_reg_req_type i_reg,
  output logic [31:0] o_reg_rdata,
  output logic o_irq
);
  localparam int TAW = $clog2(TX_DEPTH);
  localparam int RAW = $clog2(RX_DEPTH);

  typedef struct packed {
    // Buffer pointers, each with a wrap bit above the index
    logic [TAW:0] twp;
    logic [TAW:0] trp;
    logic [RAW:0] rwp;
    logic [RAW:0] rrp;
    logic [7:0] bcount;
    logic [PBF_CHW-1:0] last_chan;
    logic in_tx_pkt;
    logic in_rx_pkt;
    logic rx_bad;
    // Software visible state
    logic [PBF_NST-1:0] status;
    logic [PBF_NST-1:0] mask;
    logic [7:0] thresh_sw;
    logic [7:0] bmax;
    logic [15:0] bcw_cnt;
    // Registered outputs
    logic bp;
    logic ovf;
    logic lane_valid;
    logic [PBF_DW-1:0] lane_data;
    logic lane_bcw;
    pbf_rxout_type rxo;
    logic [31:0] rdata;
    logic irq;
  } pbf_state_type;

  // One receive buffer word: markers and the error mark travel with data
  typedef struct packed {
    logic sop;
    logic eop;
    logic err;
    logic [PBF_DW-1:0] data;
  } pbf_rxword_type;

  pbf_state_type st_r;
  pbf_state_type st_nxt;
  logic [PBF_DW-1:0] tx_mem [TX_DEPTH];
  pbf_rxword_type rx_mem [RX_DEPTH];
  logic lane_rdy_meta_r;
  logic lane_rdy_sync_r;

  // Pointers carry a wrap bit, but the difference is taken in 8 bits, so it is the fill level
  // only at depth 128; smaller depths misread once the write pointer wraps ahead of the read
  function automatic logic [7:0] fill_of(
    input logic [7:0] w,
    input logic [7:0] r
  );
    fill_of = 8'(w - r);
  endfunction

  // How many control word causes line up in one cycle; more than one is
  // a scheduling error on the user side
  function automatic logic [2:0] trig_count(
    input logic a,
    input logic b,
    input logic c,
    input logic d
  );
    trig_count = 3'(a) + 3'(b) + 3'(c) + 3'(d);
  endfunction

  // Read mux for the register port; unmapped words read as zero
  // Level word packs both fills so software sees them in one read
  function automatic logic [31:0] reg_read(
    input logic [PBF_AW-1:0] addr,
    input logic [PBF_NST-1:0] status,
    input logic [PBF_NST-1:0] mask,
    input logic [7:0] thresh,
    input logic [7:0] bmax,
    input logic [7:0] rfill,
    input logic [7:0] tfill,
    input logic [15:0] bcw_cnt
  );
    case (addr)
      PBF_REG_STATUS: reg_read = 32'(status);
      PBF_REG_MASK: reg_read = 32'(mask);
      PBF_REG_THRESH: reg_read = 32'(thresh);
      PBF_REG_BMAX: reg_read = 32'(bmax);
      PBF_REG_LEVEL: reg_read = {16'h0000, rfill, tfill};
      PBF_REG_BCWCNT: reg_read = 32'(bcw_cnt);
      default: reg_read = PBF_UNMAPPED;
    endcase
  endfunction

  // Set wins over a same-cycle clear so no event is ever lost
  function automatic logic [PBF_NST-1:0] status_next(
    input logic [PBF_NST-1:0] cur,
    input logic [PBF_NST-1:0] clr,
    input logic [PBF_NST-1:0] set
  );
    status_next = (cur & ~clr) | set;
  endfunction

  // Bytes since the last control word; a new word restarts the count
  function automatic logic [7:0] bcount_next(
    input logic bcw,
    input logic [7:0] cur
  );
    bcount_next = bcw ? 8'h04 : 8'(cur + 8'h04);
  endfunction

  // A start marker inside a packet, or data with none, means a lost marker
  function automatic logic marker_fault(
    input logic sop,
    input logic in_pkt
  );
    marker_fault = sop == in_pkt;
  endfunction

  // Lane ready arrives from the serializer side; synchronise first
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      lane_rdy_meta_r <= 1'b0;
      lane_rdy_sync_r <= 1'b0;
    end
    else
    begin
      lane_rdy_meta_r <= i_lane_ready;
      lane_rdy_sync_r <= lane_rdy_meta_r;
    end
  end

  logic [7:0] tfill;
  logic [7:0] rfill;
  logic [7:0] limit;
  logic tx_full;
  logic tx_empty;
  logic tx_push;
  logic tx_pop;
  logic rx_full;
  logic rx_push;
  logic rx_pop;
  logic trig_sop;
  logic trig_chan;
  logic trig_bmax;
  logic [2:0] ntrig;
  logic bcw_now;
  logic rx_merge_err;
  logic [PBF_NST-1:0] ev;
  logic [PBF_NST-1:0] w1c;
  pbf_rxword_type rx_word;
  // Word at the read pointer, shown before it is popped
  pbf_rxword_type rx_head;

  always_comb
  begin
    st_nxt = st_r;
    tfill = fill_of(8'(st_r.twp), 8'(st_r.trp));
    rfill = fill_of(8'(st_r.rwp), 8'(st_r.rrp));
    tx_full = tfill >= 8'(TX_DEPTH);
    tx_empty = tfill == 8'h00;
    rx_full = rfill >= 8'(RX_DEPTH);
    // Zero threshold input falls back to the software copy
    limit = (i_tx_thresh != 8'h00) ? i_tx_thresh : st_r.thresh_sw;
    tx_push = i_tx_beat.valid && !tx_full;
    tx_pop = lane_rdy_sync_r && !tx_empty;
    ev = '0;
    // Overflowed beats are dropped, never overwrite queued data
    ev[PBF_ST_TXOVF] = i_tx_beat.valid && tx_full;
    // Lane asks while the buffer is dry mid-packet
    ev[PBF_ST_TXUNF] = lane_rdy_sync_r && tx_empty && st_r.in_tx_pkt;
    trig_sop = i_tx_beat.valid && i_tx_beat.sop;
    trig_chan = i_tx_beat.valid && st_r.in_tx_pkt &&
                i_tx_beat.chan != st_r.last_chan;
    trig_bmax = i_tx_beat.valid && st_r.bcount >= st_r.bmax;
    ntrig = trig_count(trig_sop, trig_chan, trig_bmax, i_tx_bcw_force);
    bcw_now = ntrig != 3'h0;
    // Two triggers in one cycle, or a beat sent under backpressure, breaks scheduling
    ev[PBF_ST_TXBURST] = ntrig > 3'h1 ||
                         (i_tx_beat.valid && st_r.bp);

    if (tx_push)
    begin
      st_nxt.twp = st_r.twp + 1'b1;
      st_nxt.last_chan = i_tx_beat.chan;
      st_nxt.in_tx_pkt = !i_tx_beat.eop;
      st_nxt.bcount = bcount_next(bcw_now, st_r.bcount);
    end
    if (bcw_now)
    begin
      st_nxt.bcw_cnt = st_r.bcw_cnt + 16'h0001;
    end

    st_nxt.lane_valid = tx_pop;
    // Pulse marks the cycle after the trigger, not a particular data word
    st_nxt.lane_bcw = bcw_now;
    if (tx_pop)
    begin
      st_nxt.trp = st_r.trp + 1'b1;
      st_nxt.lane_data = tx_mem[st_r.trp[TAW-1:0]];
    end
    // Uses last cycle's fill, so the flag trails a write by one clock
    st_nxt.bp = tfill >= limit;
    st_nxt.ovf = st_r.ovf || ev[PBF_ST_TXOVF];

    rx_merge_err = 1'b0;
    rx_push = i_rx_lane_beat.valid && !rx_full;
    ev[PBF_ST_RXOVF] = i_rx_lane_beat.valid && rx_full;
    if (i_rx_lane_beat.valid)
    begin
      // Sop inside packet: merge into current packet; missing sop: beat opens a new packet
      rx_merge_err = marker_fault(i_rx_lane_beat.sop, st_r.in_rx_pkt);
      st_nxt.in_rx_pkt = !i_rx_lane_beat.eop;
      st_nxt.rx_bad = i_rx_lane_beat.eop ? 1'b0 :
                      (st_r.rx_bad || rx_merge_err || ev[PBF_ST_RXOVF]);
    end
    // Error mark is stored per word so it leaves with its own beat
    rx_word.sop = !st_r.in_rx_pkt;
    rx_word.eop = i_rx_lane_beat.eop;
    rx_word.err = st_r.rx_bad || rx_merge_err;
    rx_word.data = i_rx_lane_beat.data;
    if (rx_push)
      st_nxt.rwp = st_r.rwp + 1'b1;

    rx_pop = i_rx_ready && (rfill != 8'h00);
    rx_head = rx_mem[st_r.rrp[RAW-1:0]];
    st_nxt.rxo = '0;
    if (rx_pop)
    begin
      st_nxt.rrp = st_r.rrp + 1'b1;
      st_nxt.rxo.valid = 1'b1;
      st_nxt.rxo.sop = rx_head.sop;
      st_nxt.rxo.eop = rx_head.eop;
      st_nxt.rxo.data = rx_head.data;
      st_nxt.rxo.err = rx_head.err;
    end
    ev[PBF_ST_RXERR] = rx_merge_err;

    w1c = '0;
    st_nxt.rdata = PBF_UNMAPPED;
    if (i_reg.wr)
    begin
      case (i_reg.addr)
        PBF_REG_STATUS: w1c = i_reg.wdata[PBF_NST-1:0];
        PBF_REG_MASK: st_nxt.mask = i_reg.wdata[PBF_NST-1:0];
        PBF_REG_THRESH: st_nxt.thresh_sw = i_reg.wdata[7:0];
        // Burst max is only meant to move while the link is idle
        PBF_REG_BMAX: st_nxt.bmax = i_reg.wdata[7:0];
        default: w1c = '0;
      endcase
    end
    if (i_reg.rd)
    begin
      st_nxt.rdata = reg_read(i_reg.addr, st_r.status, st_r.mask,
        st_r.thresh_sw, st_r.bmax, rfill, tfill, st_r.bcw_cnt);
    end

    st_nxt.status = status_next(st_r.status, w1c, ev);
    st_nxt.irq = |(st_nxt.status & st_nxt.mask);
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r <= '0;
      st_r.thresh_sw <= PBF_THRESH_RST;
      st_r.bmax <= PBF_BMAX_RST;
      st_r.mask <= PBF_MASK_RST;
    end
    else
      st_r <= st_nxt;
  end

  // Buffer storage has no reset; pointers guard stale words
  always_ff @(posedge i_core_clk)
  begin
    // Tx words hold data only; markers are consumed at the write side
    if (tx_push)
    begin
      tx_mem[st_r.twp[TAW-1:0]] <= i_tx_beat.data;
    end
    if (rx_push)
    begin
      rx_mem[st_r.rwp[RAW-1:0]] <= rx_word;
    end
  end

  assign o_tx_backpressure = st_r.bp;
  assign o_tx_overflow = st_r.ovf;
  assign o_tx_lane_valid = st_r.lane_valid;
  assign o_tx_lane_data = st_r.lane_data;
  assign o_tx_lane_bcw = st_r.lane_bcw;
  assign o_rx_beat = st_r.rxo;
  assign o_reg_rdata = st_r.rdata;
  assign o_irq = st_r.irq;
endmodule
`default_nettype wire

// >>> src/pbf_pkg.sv
// Package: constants and carrier types for the packet bus framer
package pbf_pkg;
  localparam int PBF_DW = 32;
  localparam int PBF_CHW = 8;
  localparam int PBF_AW = 4;
  // Register word offsets
  localparam logic [3:0] PBF_REG_STATUS = 4'h0;
  localparam logic [3:0] PBF_REG_MASK = 4'h1;
  localparam logic [3:0] PBF_REG_THRESH = 4'h2;
  localparam logic [3:0] PBF_REG_BMAX = 4'h3;
  localparam logic [3:0] PBF_REG_LEVEL = 4'h4;
  localparam logic [3:0] PBF_REG_BCWCNT = 4'h5;
  // Status bit positions
  localparam int PBF_ST_TXOVF = 0;
  localparam int PBF_ST_TXUNF = 1;
  localparam int PBF_ST_TXBURST = 2;
  localparam int PBF_ST_RXERR = 3;
  localparam int PBF_ST_RXOVF = 4;
  localparam int PBF_NST = 5;
  // Reset values and the unmapped read value
  localparam logic [7:0] PBF_THRESH_RST = 8'h0C;
  localparam logic [7:0] PBF_BMAX_RST = 8'h40;
  localparam logic [4:0] PBF_MASK_RST = 5'h00;
  localparam logic [31:0] PBF_UNMAPPED = 32'h00000000;

  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic [PBF_CHW-1:0] chan;
    logic [PBF_DW-1:0] data;
  } pbf_beat_type;

  typedef struct packed {
    logic valid;
    logic sop;
    logic eop;
    logic err;
    logic [PBF_DW-1:0] data;
  } pbf_rxout_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [PBF_AW-1:0] addr;
    logic [31:0] wdata;
  } pbf_reg_req_type;
endpackage

// >>> tb/pbf_framer_asserts.sv
// Port assertions for the packet bus framer
`timescale 1ns/1ps
`default_nettype none
module pbf_framer_asserts
  import pbf_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire pbf_beat_type i_tx_beat,
  input wire logic i_tx_bcw_force,
  input wire logic [7:0] i_tx_thresh,
  input wire logic i_lane_ready,
  input wire logic o_tx_backpressure,
  input wire logic o_tx_overflow,
  input wire logic o_tx_lane_bcw,
  input wire logic i_rx_ready,
  input wire pbf_rxout_type o_rx_beat,
  input wire pbf_reg_req_type i_reg,
  input wire logic o_irq
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_ovf_sticky: assert property (o_tx_overflow |=> o_tx_overflow)
    else $error("overflow fell");
  a_ovf_cause: assert property ($rose(o_tx_overflow) |->
    $past(i_tx_beat.valid)) else $error("overflow unprompted");
  a_bcw_sop: assert property (i_tx_beat.valid && i_tx_beat.sop |=>
    o_tx_lane_bcw) else $error("no bcw on sop");
  a_bcw_force: assert property (i_tx_bcw_force |=> o_tx_lane_bcw)
    else $error("no forced bcw");
  a_bcw_cause: assert property (o_tx_lane_bcw |->
    $past(i_tx_bcw_force || i_tx_beat.valid)) else $error("stray bcw");
  // Lane held idle so nothing can drain the single word
  a_bp_reach: assert property ((!i_lane_ready[*3] ##0
    (i_tx_beat.valid && i_tx_thresh == 8'h01)) ##1 !i_lane_ready[*3]
    |-> o_tx_backpressure) else $error("no backpressure");
  a_rx_cause: assert property (o_rx_beat.valid |-> $past(i_rx_ready))
    else $error("rx beat unasked");
  a_irq_mask: assert property (i_reg.wr && i_reg.addr == PBF_REG_MASK
    && i_reg.wdata == 32'h0 |=> ##1 !o_irq) else $error("irq unmasked");
endmodule
`default_nettype wire

// >>> tb/pbf_user_model.sv
// User-side model that drains the receive packet bus
`timescale 1ns/1ps
`default_nettype none
module pbf_user_model
  import pbf_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire pbf_rxout_type i_rx_beat,
  output logic o_rx_ready,
  output logic [7:0] o_err_cnt
);
  // Drains faster than the link unless told to stall
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rx_ready <= 1'b0;
      o_err_cnt <= 8'h00;
    end
    else
    begin
      o_rx_ready <= !i_slow;
      if (i_rx_beat.valid && i_rx_beat.err)
        o_err_cnt <= o_err_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Directed bench for the packet bus framer
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pbf_pkg::*;
;
  logic clk, rst, frc, lrdy, slow, bp, ovf, lv, lbcw, irq, rrdy;
  logic [7:0] thr, errs;
  logic [31:0] ld, rdat;
  pbf_beat_type tx, rx;
  pbf_reg_req_type rq;
  pbf_rxout_type rxo;
  int error_cnt, total_checks;

  pbf_framer pbf_framer_i (.i_core_clk(clk), .i_rst(rst), .i_tx_beat(tx),
    .i_tx_bcw_force(frc), .i_tx_thresh(thr), .i_lane_ready(lrdy),
    .o_tx_backpressure(bp), .o_tx_overflow(ovf), .o_tx_lane_valid(lv),
    .o_tx_lane_data(ld), .o_tx_lane_bcw(lbcw), .i_rx_lane_beat(rx),
    .i_rx_ready(rrdy), .o_rx_beat(rxo), .i_reg(rq), .o_reg_rdata(rdat),
    .o_irq(irq));
  pbf_user_model pbf_user_model_i (.i_core_clk(clk), .i_rst(rst),
    .i_slow(slow), .i_rx_beat(rxo), .o_rx_ready(rrdy), .o_err_cnt(errs));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // Reads compare against d; one idle cycle keeps strobes single-driven
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    rq <= '{w, !w, a, d};
    @(posedge clk);
    rq <= '0;
    @(posedge clk);
    if (!w)
      chk(rdat, d);
  endtask

  task automatic send(input logic to_rx, input logic s, input logic e,
    input logic [31:0] d);
    if (to_rx)
      rx <= '{1'b1, s, e, 8'h00, d};
    else
      tx <= '{1'b1, s, e, 8'h00, d};
    @(posedge clk);
    rx <= '0;
    tx <= '0;
    @(posedge clk);
  endtask

  task automatic tend(input int n);
    $display("test %0d done", n);
  endtask

  task automatic test_done;
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    error_cnt++;
    test_done;
  end

  initial
  begin
    error_cnt = 0;
    total_checks = 0;
    {rst, frc, lrdy, slow} = 4'h8;
    {tx, rx, rq, thr} = '0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, PBF_REG_THRESH, 32'h0000000C);
    bus(1'b0, PBF_REG_BMAX, 32'h00000040);
    bus(1'b0, PBF_REG_MASK, 32'h00000000);
    bus(1'b0, 4'hF, PBF_UNMAPPED);
    tend(1);
    thr <= 8'h01;
    send(1'b0, 1'b1, 1'b0, 32'h000000A1);
    chk(lbcw, 1'b1);
    frc <= 1'b1;
    @(posedge clk);
    frc <= 1'b0;
    @(posedge clk);
    chk(lbcw, 1'b1);
    repeat (2) @(posedge clk);
    chk(bp, 1'b1);
    bus(1'b0, PBF_REG_BCWCNT, 32'h00000002);
    tend(2);
    bus(1'b1, PBF_REG_MASK, 32'h0000001F);
    repeat (17) send(1'b0, 1'b0, 1'b0, 32'h000000B2);
    chk(ovf, 1'b1);
    chk(irq, 1'b1);
    bus(1'b0, PBF_REG_STATUS, 32'h00000005);
    bus(1'b1, PBF_REG_STATUS, 32'h00000005);
    bus(1'b0, PBF_REG_STATUS, 32'h00000000);
    bus(1'b1, PBF_REG_MASK, 32'h00000000);
    chk(ovf, 1'b1);
    rst <= 1'b1;
    thr <= 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(ovf, 1'b0);
    tend(3);
    while (bp) @(posedge clk);
    send(1'b0, 1'b1, 1'b0, 32'hC0DE0001);
    lrdy <= 1'b1;
    repeat (12) if (lv !== 1'b1) @(posedge clk);
    chk(ld, 32'hC0DE0001);
    repeat (6) @(posedge clk);
    lrdy <= 1'b0;
    bus(1'b0, PBF_REG_STATUS, 32'h00000002);
    tend(4);
    send(1'b1, 1'b1, 1'b0, 32'h00000D01);
    @(posedge clk);
    chk(rxo.data, 32'h00000D01);
    send(1'b1, 1'b0, 1'b0, 32'h00000D02);
    send(1'b1, 1'b1, 1'b0, 32'h00000D03);
    send(1'b1, 1'b0, 1'b1, 32'h00000D04);
    repeat (4) @(posedge clk);
    chk(errs, 8'h02);
    bus(1'b0, PBF_REG_STATUS, 32'h0000000A);
    slow <= 1'b1;
    bus(1'b1, PBF_REG_STATUS, 32'h0000001F);
    send(1'b1, 1'b1, 1'b0, 32'h00000E04);
    repeat (16) send(1'b1, 1'b0, 1'b0, 32'h00000E05);
    bus(1'b0, PBF_REG_STATUS, 32'h00000010);
    slow <= 1'b0;
    repeat (40) @(posedge clk);
    tend(5);
    test_done;
  end
endmodule

bind pbf_framer pbf_framer_asserts pbf_framer_asserts_i (.i_core_clk,
  .i_rst, .i_tx_beat, .i_tx_bcw_force, .i_tx_thresh, .i_lane_ready,
  .o_tx_backpressure, .o_tx_overflow, .o_tx_lane_bcw, .i_rx_ready,
  .o_rx_beat, .i_reg, .o_irq);
`default_nettype wire
